// File: pkg/tcb_consts.vh
`ifndef TCB_CONSTS_VH
`define TCB_CONSTS_VH

// Number of configuration words and their width.
`define TCB_NUM_WORDS        7
`define TCB_WORD_W           32
`define TCB_TAG_W            8

// Serial opcodes: upper five bits select the command, lower three the word index.
`define TCB_OP_WRITE         5'h10
`define TCB_OP_READ_TAG      5'h16

// Reset values of the configuration words.
`define TCB_RST_WORD_0       32'h22066800
`define TCB_RST_WORD_1       32'h55408000
`define TCB_RST_WORD_X       32'h00000000

// Field positions in configuration word 0.
`define TCB_W0_FIRE_LO_MSB   31
`define TCB_W0_FIRE_LO_LSB   28
`define TCB_W0_FIRE_DIV_MSB  27
`define TCB_W0_FIRE_DIV_LSB  24
`define TCB_W0_CAL_PER_MSB   23
`define TCB_W0_CAL_PER_LSB   22
`define TCB_W0_HS_DIV_MSB    21
`define TCB_W0_HS_DIV_LSB    20
`define TCB_W0_START_MSB     19
`define TCB_W0_START_LSB     18
`define TCB_W0_TEMP_PORTS    17
`define TCB_W0_TEMP_CYCLE    16
`define TCB_W0_TEMP_WARMUP   15
`define TCB_W0_TEMP_CLKSEL   14
`define TCB_W0_ALU_CAL       13
`define TCB_W0_NO_AUTO_CAL   12
`define TCB_W0_RANGE_TWO     11
`define TCB_W0_INV_STOP2     10
`define TCB_W0_INV_STOP1     9
`define TCB_W0_INV_START     8

// Field positions in configuration word 6.
`define TCB_W6_FIRE_HI_MSB   30
`define TCB_W6_FIRE_HI_LSB   28
`define TCB_W6_START_HI      20

// Fire pulse count above which the phase pattern is not applied.
`define TCB_FIRE_PHASE_MAX   7'h0f

// Clock period and oscillator start-up waits, in nanoseconds.
`define TCB_CLK_PERIOD_NS    4
`define TCB_T_START_480US_NS 480000
`define TCB_T_START_1M46_NS  1460000
`define TCB_T_START_2M44_NS  2440000
`define TCB_T_START_5M14_NS  5140000

`endif

// File: logic/tcb_config_bank.v
`timescale 1ns/1ps
`include "tcb_consts.vh"

module tcb_config_bank #(
   parameter START_WAIT_0_CYC = `TCB_T_START_480US_NS / `TCB_CLK_PERIOD_NS,
   parameter START_WAIT_1_CYC = `TCB_T_START_1M46_NS / `TCB_CLK_PERIOD_NS,
   parameter START_WAIT_2_CYC = `TCB_T_START_2M44_NS / `TCB_CLK_PERIOD_NS,
   parameter START_WAIT_3_CYC = `TCB_T_START_5M14_NS / `TCB_CLK_PERIOD_NS
) (
   input  wire       mclk,
   input  wire       rst_b,
   input  wire       spi_ssn_b,
   input  wire       spi_sck,
   input  wire       spi_mosi,
   output reg        spi_miso,
   output reg        spi_miso_oe,
   input  wire       meas_request,
   input  wire       meas_done,
   input  wire       start_in,
   input  wire       stop_ch1_in,
   input  wire       stop_ch2_in,
   output reg        start_event,
   output reg        stop_ch1_event,
   output reg        stop_ch2_event,
   output reg  [6:0] fire_pulse_count,
   output reg        fire_enable,
   output reg        fire_phase_pattern_apply,
   output reg        fire_clk_en,
   output reg  [4:0] cal_period_count,
   output reg  [2:0] hs_ref_divider,
   output reg  [2:0] hs_osc_startup_sel,
   output reg        hs_osc_on,
   output reg        hs_osc_ready,
   output reg  [2:0] temp_port_count,
   output reg        temp_cycle_time,
   output reg  [2:0] temp_warmup_count,
   output reg        temp_clock_select,
   output reg        alu_cal_enable,
   output reg        auto_cal_enable,
   output reg        range_two_select
);

   localparam ST_OPCODE = 4'b0001;
   localparam ST_WDATA  = 4'b0010;
   localparam ST_RDATA  = 4'b0100;
   localparam ST_IGNORE = 4'b1000;

   localparam OS_OFF    = 3'b001;
   localparam OS_WAIT   = 3'b010;
   localparam OS_READY  = 3'b100;

   localparam [20:0] WAIT_0 = START_WAIT_0_CYC[20:0];
   localparam [20:0] WAIT_1 = START_WAIT_1_CYC[20:0];
   localparam [20:0] WAIT_2 = START_WAIT_2_CYC[20:0];
   localparam [20:0] WAIT_3 = START_WAIT_3_CYC[20:0];

   reg  [31:0] cfg_word [0:6];
   reg  [3:0]  spi_state;
   reg         sck_prev;
   reg  [4:0]  bit_cnt;
   reg  [31:0] rx_shift;
   reg  [2:0]  word_sel;
   reg  [7:0]  tx_shift;
   reg  [3:0]  fire_div_cnt;
   reg  [2:0]  osc_state;
   reg  [20:0] osc_cnt;
   reg  [2:0]  edge_prev;
   wire [2:0]  edge_in;
   wire [2:0]  edge_inv;
   wire [2:0]  edge_hit;
   wire        sck_rise;
   wire        sck_fall;
   wire [31:0] rx_next;
   wire [31:0] word0;
   wire [31:0] word6;
   wire [6:0]  next_fire_count;
   wire [2:0]  next_start_sel;
   reg  [20:0] next_wait;
   integer     i;

   assign sck_rise = spi_sck & ~sck_prev;
   assign sck_fall = ~spi_sck & sck_prev;
   assign rx_next  = {rx_shift[30:0], spi_mosi};
   assign word0    = cfg_word[0];
   assign word6    = cfg_word[6];

   ////////////////////////////////////////////////////////////////////////////////
   // Serial slave

   // Inputs are synchronous to mclk, so one stage is enough to find clock edges.
   always @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         sck_prev <= 1'b0;
      end else begin
         sck_prev <= spi_sck;
      end
   end

   // MSB-first frame
   // Data is sampled on the falling edge and launched on the rising edge.
   always @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         spi_state   <= ST_OPCODE;
         bit_cnt     <= 5'h00;
         rx_shift    <= 32'h00000000;
         word_sel    <= 3'h0;
         tx_shift    <= 8'h00;
         spi_miso    <= 1'b0;
         spi_miso_oe <= 1'b0;
         for (i = 0; i < `TCB_NUM_WORDS; i = i + 1) begin
            cfg_word[i] <= (i == 0) ? `TCB_RST_WORD_0 : ((i == 1) ? `TCB_RST_WORD_1 : `TCB_RST_WORD_X);
         end
      end else if (spi_ssn_b) begin
         // Deselect aborts any partial word, so nothing half-shifted is kept.
         spi_state   <= ST_OPCODE;
         bit_cnt     <= 5'h00;
         spi_miso_oe <= 1'b0;
      end else begin
         spi_miso_oe <= 1'b1;
         if (sck_rise && spi_state == ST_RDATA) begin
            spi_miso <= tx_shift[7];
            tx_shift <= {tx_shift[6:0], 1'b0};
         end
         if (sck_fall) begin
            rx_shift <= rx_next;
            bit_cnt  <= bit_cnt + 5'h01;
            case (spi_state)
               ST_OPCODE: begin
                  if (bit_cnt == 5'h07) begin
                     bit_cnt  <= 5'h00;
                     word_sel <= rx_next[2:0];
                     if (rx_next[2:0] == 3'h7) begin
                        spi_state <= ST_IGNORE;
                     end else if (rx_next[7:3] == `TCB_OP_WRITE) begin
                        spi_state <= ST_WDATA;
                     end else if (rx_next[7:3] == `TCB_OP_READ_TAG) begin
                        tx_shift  <= cfg_word[rx_next[2:0]][7:0];
                        spi_state <= ST_RDATA;
                     end else begin
                        spi_state <= ST_IGNORE;
                     end
                  end
               end
               ST_WDATA: begin
                  if (bit_cnt == 5'h1f) begin
                     cfg_word[word_sel] <= rx_next;
                     spi_state          <= ST_IGNORE;
                  end
               end
               ST_RDATA: begin
                  if (bit_cnt == 5'h07) begin
                     spi_state <= ST_IGNORE;
                  end
               end
               default: begin
                  bit_cnt <= 5'h00;
               end
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Decoded configuration fields

   // seven-bit count from words 0 and 6
   assign next_fire_count = {word6[`TCB_W6_FIRE_HI_MSB:`TCB_W6_FIRE_HI_LSB],
                             word0[`TCB_W0_FIRE_LO_MSB:`TCB_W0_FIRE_LO_LSB]};
   // top select bit comes from word 6
   assign next_start_sel  = {word6[`TCB_W6_START_HI], word0[`TCB_W0_START_MSB:`TCB_W0_START_LSB]};

   // tag byte unused
   // Fields are registered so every output stands on a flop; word 0 tag bits feed no field and only return through the tag read.
   always @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         fire_pulse_count         <= 7'h00;
         fire_enable              <= 1'b0;
         fire_phase_pattern_apply <= 1'b0;
         cal_period_count         <= 5'h02;
         hs_ref_divider           <= 3'h1;
         hs_osc_startup_sel       <= 3'h0;
         temp_port_count          <= 3'h2;
         temp_cycle_time          <= 1'b0;
         temp_warmup_count        <= 3'h2;
         temp_clock_select        <= 1'b0;
         alu_cal_enable           <= 1'b1;
         auto_cal_enable          <= 1'b1;
         range_two_select         <= 1'b0;
      end else begin
         fire_pulse_count   <= next_fire_count;
         fire_enable        <= (next_fire_count != 7'h00);
         fire_phase_pattern_apply <= (next_fire_count != 7'h00) && (next_fire_count <= `TCB_FIRE_PHASE_MAX);
         // two to the code plus one
         cal_period_count   <= 5'h02 << word0[`TCB_W0_CAL_PER_MSB:`TCB_W0_CAL_PER_LSB];
         // divide by 1, 2, 4, 4
         if (word0[`TCB_W0_HS_DIV_MSB]) begin
            hs_ref_divider <= 3'h4;
         end else if (word0[`TCB_W0_HS_DIV_LSB]) begin
            hs_ref_divider <= 3'h2;
         end else begin
            hs_ref_divider <= 3'h1;
         end
         hs_osc_startup_sel <= next_start_sel;
         temp_port_count    <= word0[`TCB_W0_TEMP_PORTS] ? 3'h4 : 3'h2;
         temp_cycle_time    <= word0[`TCB_W0_TEMP_CYCLE];
         temp_warmup_count  <= word0[`TCB_W0_TEMP_WARMUP] ? 3'h7 : 3'h2;
         temp_clock_select  <= word0[`TCB_W0_TEMP_CLKSEL];
         // calibration forced in range 2
         // Range 2 cannot run uncalibrated, so a cleared bit there is overridden.
         alu_cal_enable     <= word0[`TCB_W0_ALU_CAL] | word0[`TCB_W0_RANGE_TWO];
         auto_cal_enable    <= ~word0[`TCB_W0_NO_AUTO_CAL];
         range_two_select   <= word0[`TCB_W0_RANGE_TWO];
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Fire clock divider

   // divide by field plus one
   // A change of ratio takes effect at the next wrap, never mid-period.
   always @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         fire_div_cnt <= 4'h0;
         fire_clk_en  <= 1'b0;
      end else if (fire_div_cnt == 4'h0) begin
         fire_div_cnt <= word0[`TCB_W0_FIRE_DIV_MSB:`TCB_W0_FIRE_DIV_LSB];
         fire_clk_en  <= 1'b1;
      end else begin
         fire_div_cnt <= fire_div_cnt - 4'h1;
         fire_clk_en  <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // High-speed oscillator start-up

   always @* begin
      next_wait = WAIT_3;
      case (next_start_sel)
         3'h2:    next_wait = WAIT_0;
         3'h3:    next_wait = WAIT_1;
         3'h4:    next_wait = WAIT_2;
         default: next_wait = WAIT_3;
      endcase
   end

   always @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         osc_state    <= OS_OFF;
         osc_cnt      <= 21'h000000;
         hs_osc_on    <= 1'b0;
         hs_osc_ready <= 1'b0;
      end else if (next_start_sel == 3'h0) begin
         osc_state    <= OS_OFF;
         hs_osc_on    <= 1'b0;
         hs_osc_ready <= 1'b0;
      end else if (next_start_sel == 3'h1) begin
         osc_state    <= OS_READY;
         hs_osc_on    <= 1'b1;
         hs_osc_ready <= 1'b1;
      end else begin
         case (osc_state)
            OS_OFF: begin
               hs_osc_on    <= meas_request;
               hs_osc_ready <= 1'b0;
               if (meas_request) begin
                  osc_cnt   <= next_wait - 21'h000001;
                  osc_state <= OS_WAIT;
               end
            end
            OS_WAIT: begin
               if (osc_cnt == 21'h000000) begin
                  hs_osc_ready <= 1'b1;
                  osc_state    <= OS_READY;
               end else begin
                  osc_cnt <= osc_cnt - 21'h000001;
               end
            end
            default: begin
               // Leaving always-on mode also lands here; a done drops the oscillator.
               if (meas_done) begin
                  hs_osc_on    <= 1'b0;
                  hs_osc_ready <= 1'b0;
                  osc_state    <= OS_OFF;
               end
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Input edge selection

   assign edge_in  = {stop_ch2_in, stop_ch1_in, start_in};
   assign edge_inv = {word0[`TCB_W0_INV_STOP2], word0[`TCB_W0_INV_STOP1], word0[`TCB_W0_INV_START]};

   genvar g;
   generate
      for (g = 0; g < 3; g = g + 1) begin : g_edge
         assign edge_hit[g] = edge_inv[g] ? (edge_prev[g] & ~edge_in[g]) : (~edge_prev[g] & edge_in[g]);
      end
   endgenerate

   // Previous levels and one-cycle event pulses.
   always @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         edge_prev      <= 3'h0;
         start_event    <= 1'b0;
         stop_ch1_event <= 1'b0;
         stop_ch2_event <= 1'b0;
      end else begin
         edge_prev      <= edge_in;
         start_event    <= edge_hit[0];
         stop_ch1_event <= edge_hit[1];
         stop_ch2_event <= edge_hit[2];
      end
   end

endmodule // tcb_config_bank

// File: sim/tcb_host_model.sv
`timescale 1ns/1ps

module tcb_host_model (
   input  wire logic mclk,
   input  wire logic spi_miso,
   output logic      spi_ssn_b,
   output logic      spi_sck,
   output logic      spi_mosi
);
   // Deselected with the serial clock parked low, as between frames.
   initial begin
      spi_ssn_b = 1'b1;
      spi_sck   = 1'b0;
      spi_mosi  = 1'b0;
   end

   // mode one, msb first.
   // Each clock phase lasts three mclk so the bank sees every level three times.
   // Read bits are taken just before the fall, after the bank has settled.
   task frame(input logic [7:0] op, input logic [31:0] data, input int nbits, output logic [7:0] rx);
      logic [39:0] sh;
      begin
         sh = {op, data};
         rx = 8'h00;
         @(posedge mclk) spi_ssn_b <= 1'b0;
         repeat (3) @(posedge mclk);
         for (int i = 0; i < nbits; i++) begin
            spi_sck  <= 1'b1;
            spi_mosi <= sh[39 - i];
            repeat (3) @(posedge mclk);
            rx = {rx[6:0], spi_miso};
            spi_sck <= 1'b0;
            repeat (3) @(posedge mclk);
         end
         spi_ssn_b <= 1'b1;
         spi_mosi  <= ~spi_mosi;
         repeat (3) @(posedge mclk);
      end
   endtask
endmodule // tcb_host_model

// File: sim/tcb_config_bank_asserts.sv
`timescale 1ns/1ps

module tcb_config_bank_asserts (
   input wire logic       mclk,
   input wire logic       rst_b,
   input wire logic       spi_ssn_b,
   input wire logic       spi_miso_oe,
   input wire logic       start_in,
   input wire logic       start_event,
   input wire logic       stop_ch1_event,
   input wire logic [6:0] fire_pulse_count,
   input wire logic       fire_enable,
   input wire logic       fire_phase_pattern_apply,
   input wire logic [4:0] cal_period_count,
   input wire logic [2:0] hs_ref_divider,
   input wire logic       hs_osc_on,
   input wire logic       hs_osc_ready,
   input wire logic [2:0] temp_port_count,
   input wire logic [2:0] temp_warmup_count,
   input wire logic       alu_cal_enable,
   input wire logic       range_two_select
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_b);

   ////////////////////////////////////////////////////////////////////////////////
   // Decoded fields must always agree with one another and with legal codes.
   fire_gate_a: assert property (
      fire_enable == (fire_pulse_count != 7'h00)) else $error("fire enable disagrees with count");
   phase_limit_a: assert property (
      fire_phase_pattern_apply == (fire_pulse_count != 7'h00 && fire_pulse_count <= 7'h0f))
      else $error("phase pattern applied outside count range");
   cal_period_a: assert property (
      cal_period_count inside {5'h02, 5'h04, 5'h08, 5'h10}) else $error("bad calibration period");
   hs_divider_a: assert property (
      hs_ref_divider inside {3'h1, 3'h2, 3'h4}) else $error("bad reference divider");
   osc_ready_a: assert property (
      hs_osc_ready |-> hs_osc_on) else $error("oscillator ready while off");
   temp_codes_a: assert property (
      temp_port_count inside {3'h2, 3'h4} && temp_warmup_count inside {3'h2, 3'h7})
      else $error("bad temperature port or warm-up count");
   range_cal_a: assert property (
      range_two_select |-> alu_cal_enable) else $error("calibration off in range two");

   ////////////////////////////////////////////////////////////////////////////////
   // An event needs a recent input change, and is a single-cycle pulse.
   event_cause_a: assert property (
      start_event |-> ($past(start_in) != $past(start_in, 2)) || ($past(start_in, 2) != $past(start_in, 3)))
      else $error("start event without input change");
   event_pulse_a: assert property (
      stop_ch1_event |=> !stop_ch1_event) else $error("stop event longer than one cycle");
   // Settings may only move while a frame is open, never on a stray edge.
   // The first decode of the reset words lands one cycle after release, so two cycles are skipped.
   cfg_atomic_a: assert property (
      $past(rst_b, 2) && (!$stable(range_two_select) || !$stable(fire_pulse_count)) |-> !$past(spi_ssn_b))
      else $error("setting changed outside a frame");
   // The data pin is driven from the edge after select until the edge after deselect.
   miso_drive_a: assert property (
      spi_miso_oe == !$past(spi_ssn_b)) else $error("data output enable out of step with select");
endmodule // tcb_config_bank_asserts

bind tcb_config_bank tcb_config_bank_asserts u_chk (
   .mclk(mclk), .rst_b(rst_b), .spi_ssn_b(spi_ssn_b), .start_in(start_in), .start_event(start_event),
   .stop_ch1_event(stop_ch1_event), .fire_pulse_count(fire_pulse_count), .fire_enable(fire_enable),
   .fire_phase_pattern_apply(fire_phase_pattern_apply), .cal_period_count(cal_period_count),
   .hs_ref_divider(hs_ref_divider), .hs_osc_on(hs_osc_on), .hs_osc_ready(hs_osc_ready),
   .temp_port_count(temp_port_count), .temp_warmup_count(temp_warmup_count),
   .alu_cal_enable(alu_cal_enable), .range_two_select(range_two_select), .spi_miso_oe(spi_miso_oe));

// File: sim/testbench.sv
`timescale 1ns/1ps
`include "tcb_consts.vh"

module testbench;
   logic       mclk, rst_b, meas_request, meas_done, start_in, stop_ch1_in, stop_ch2_in;
   logic       ssn_b, sck, mosi, miso, sev, s1ev, s2ev, fen, fpa, fck, hon, hrdy, tcyc, tcks, alu, auto, rng;
   logic [6:0] fcnt;
   logic [4:0] cal;
   logic [2:0] hdiv, hsel, tport, twarm;
   logic [7:0] rx;
   int         bad_count, n_compared, hits;

   // Free-running 250 MHz clock.
   always #2 mclk = ~mclk;

   tcb_config_bank #(.START_WAIT_0_CYC(5), .START_WAIT_1_CYC(6), .START_WAIT_2_CYC(7), .START_WAIT_3_CYC(8))
   u_tcb_config_bank (
      .mclk(mclk), .rst_b(rst_b), .spi_ssn_b(ssn_b), .spi_sck(sck), .spi_mosi(mosi), .spi_miso(miso),
      .spi_miso_oe(), .meas_request(meas_request), .meas_done(meas_done), .start_in(start_in),
      .stop_ch1_in(stop_ch1_in), .stop_ch2_in(stop_ch2_in), .start_event(sev), .stop_ch1_event(s1ev),
      .stop_ch2_event(s2ev), .fire_pulse_count(fcnt), .fire_enable(fen), .fire_phase_pattern_apply(fpa),
      .fire_clk_en(fck), .cal_period_count(cal), .hs_ref_divider(hdiv), .hs_osc_startup_sel(hsel),
      .hs_osc_on(hon), .hs_osc_ready(hrdy), .temp_port_count(tport), .temp_cycle_time(tcyc),
      .temp_warmup_count(twarm), .temp_clock_select(tcks), .alu_cal_enable(alu), .auto_cal_enable(auto),
      .range_two_select(rng));

   tcb_host_model u_tcb_host_model (
      .mclk(mclk), .spi_miso(miso), .spi_ssn_b(ssn_b), .spi_sck(sck), .spi_mosi(mosi));

   ////////////////////////////////////////////////////////////////////////////////
   // Case equality so that an unknown never counts as a match.
   task check(input logic [31:0] seen, input logic [31:0] expv, input string what);
      n_compared++;
      if (seen !== expv) begin
         bad_count++;
         $display("unexpected %s expected %h seen %h", what, expv, seen);
      end
   endtask

   task stop_test;
      $display("compared %0d mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   task wr(input logic [2:0] idx, input logic [31:0] data, input int nbits);
      u_tcb_host_model.frame({`TCB_OP_WRITE, idx}, data, nbits, rx);
   endtask

   task rd_tag(input logic [2:0] idx, input logic [7:0] expv);
      u_tcb_host_model.frame({`TCB_OP_READ_TAG, idx}, 32'h0, 16, rx);
      check(rx, expv, "tag");
   endtask

   // Drives all three edge inputs and reports whether each produced an event.
   task edge_probe(input logic lvl, input logic [2:0] expv);
      logic [2:0] seen;
      seen = 3'b000;
      start_in    <= lvl;
      stop_ch1_in <= lvl;
      stop_ch2_in <= lvl;
      repeat (6) begin
         @(posedge mclk);
         seen = seen | {sev, s1ev, s2ev};
      end
      check(seen, expv, "edge events");
   endtask

   // Cuts a hung run short well beyond the expected length of all tests.
   initial begin
      repeat (40000) @(posedge mclk);
      bad_count++;
      stop_test;
   end

   initial begin
      mclk = 1'b0; rst_b = 1'b0; meas_request = 1'b0; meas_done = 1'b0;
      start_in = 1'b0; stop_ch1_in = 1'b0; stop_ch2_in = 1'b0;
      bad_count = 0; n_compared = 0;
      repeat (5) @(posedge mclk);
      rst_b <= 1'b1;
      repeat (3) @(posedge mclk);
      check({fcnt, cal, hdiv, tport, tcks, alu, auto, rng}, {7'h2, 5'h2, 3'h1, 3'h4, 4'hf}, "reset");
      for (int i = 0; i < 7; i++) rd_tag(i[2:0], 8'h00);
      $display("reset test done");

      // Boundary fire counts 0, 15, 16, 31 and every code of the two-bit fields.
      for (int k = 0; k < 4; k++) begin
         logic [1:0] c;
         logic [6:0] n;
         c = k[1:0];
         n = {2'b00, c[1], {4{c[0]}}};
         wr(3'h6, {1'b0, n[6:4], 7'h0, c[1], 12'h0, 6'h18, c}, 40);
         wr(3'h0, {n[3:0], 4'h2, c, c, c, c[0], c[1], c[0], c[1], c[0] | c[1], c[0], c[1], 3'h0, 6'h28, c}, 40);
         check({fcnt, fen, fpa}, {n, n != 0, n != 0 && n <= 15}, "fire");
         check(cal, 5'h2 << k, "cal period");
         check(hdiv, (k == 0) ? 3'h1 : (k == 1) ? 3'h2 : 3'h4, "hs divider");
         check(hsel, {c[1], c}, "startup");
         check({tport, tcyc, twarm, tcks}, {c[0] ? 3'h4 : 3'h2, c[1], c[0] ? 3'h7 : 3'h2, c[1]}, "temp");
         check({alu, auto, rng}, {c[0] | c[1], ~c[0], c[1]}, "cal and range");
         rd_tag(3'h0, {6'h28, c});
         rd_tag(3'h6, {6'h18, c});
      end
      $display("field test done");

      // Ready kept over from always-on mode, then off on completion, then a fresh wait.
      meas_request <= 1'b1;
      @(posedge mclk) meas_request <= 1'b0;
      repeat (14) @(posedge mclk);
      check({hon, hrdy}, 2'b11, "osc ready");
      meas_done <= 1'b1;
      @(posedge mclk) meas_done <= 1'b0;
      repeat (3) @(posedge mclk);
      check({hon, hrdy}, 2'b00, "osc off");
      meas_request <= 1'b1;
      @(posedge mclk) meas_request <= 1'b0;
      repeat (2) @(posedge mclk);
      check({hon, hrdy}, 2'b10, "osc waiting");
      $display("oscillator test done");

      // A frame cut off mid-word must leave the word untouched.
      wr(3'h0, 32'h0, 28);
      check({rng, fcnt}, {1'b1, 7'h1f}, "partial write");
      rd_tag(3'h0, 8'ha3);
      $display("partial write test done");

      // Divider extremes and both polarities of the edge inputs.
      for (int p = 0; p < 2; p++) begin
         wr(3'h0, {4'h1, p ? 4'hf : 4'h0, 12'h000, 1'b0, {3{p[0]}}, 8'h5a}, 40);
         hits = 0;
         repeat (48) begin
            @(posedge mclk);
            hits += fck;
         end
         check(hits, p ? 3 : 48, "fire clock");
         edge_probe(1'b1, p ? 3'b000 : 3'b111);
         edge_probe(1'b0, p ? 3'b111 : 3'b000);
      end
      $display("divider and edge test done");

      // Every start-up code: off, always on, and each wait counted from the request.
      // The waits follow the shortened instance parameters above: 5, 6, 7, then 8 cycles.
      for (int s = 0; s < 8; s++) begin
         logic [2:0] q;
         int         w;
         q = s[2:0];
         w = (q < 3'h5) ? q + 3 : 8;
         wr(3'h6, {11'h000, q[2], 20'h00000}, 40);
         wr(3'h0, {12'h000, q[1:0], 18'h00000}, 40);
         check(hsel, q, "startup code");
         meas_done <= 1'b1;
         @(posedge mclk) meas_done <= 1'b0;
         @(posedge mclk) meas_request <= 1'b1;
         @(posedge mclk) meas_request <= 1'b0;
         repeat (w) @(posedge mclk);
         check({hon, hrdy}, (q == 3'h0) ? 2'b00 : ((q == 3'h1) ? 2'b11 : 2'b10), "osc before wait end");
         @(posedge mclk);
         check({hon, hrdy}, (q == 3'h0) ? 2'b00 : 2'b11, "osc after wait end");
      end
      $display("start-up code test done");
      stop_test;
   end
endmodule // testbench
